//--- include/io_cell_pkg.sv
// Purpose: shared constants and types for the programmable i/o cell
// Assumes: 16-pin routing pool split into four quarter-sized pin sets
// Notes: register offsets are byte addresses on an axi4-lite bus
package io_cell_pkg;
  localparam int POOL_PINS = 16;
  localparam int QUARTER = 4;
  localparam int PICK_W = 2;
  localparam int ADDR_W = 8;
  // quarter of the pool that serves each control function
  localparam int SET_OE = 0;
  localparam int SET_CLK = 1;
  localparam int SET_SEL_ONE = 2;
  localparam int SET_SEL_TWO = 3;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ROUTE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control word fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INPUT_PATH = 2;
  localparam int CTRL_OUT_INV = 3;
  localparam int CTRL_CONST_EN = 4;
  localparam int CTRL_CONST_VAL = 5;
  localparam int CTRL_OE_INV = 6;
  localparam int CTRL_CLK_INV = 7;
  localparam int CTRL_GATE_INV = 8;
  localparam int CTRL_SLO_INV = 9;
  localparam int CTRL_SHI_INV = 10;
  localparam int CTRL_CLK_DED = 11;
  localparam int CTRL_GATE_GLB = 12;
  localparam int CTRL_SLO_SET = 13;
  localparam int CTRL_SHI_SET = 14;
  localparam int CTRL_USED = 15;
  // routing word fields
  localparam int ROUTE_DATA_LSB = 0;
  localparam int ROUTE_NBR_LSB = 8;
  localparam int ROUTE_OE_LSB = 12;
  localparam int ROUTE_CLK_LSB = 14;
  localparam int ROUTE_GATE_LSB = 16;
  localparam int ROUTE_SLO_LSB = 18;
  localparam int ROUTE_SHI_LSB = 20;
  localparam int ROUTE_USED = 22;

  typedef enum logic [1:0] {
    STORE_BYPASS,
    STORE_LATCH,
    STORE_REG
  } store_mode_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] route;
  } cfg_t;

  typedef struct packed {
    logic clk_active;
    logic gate_on;
    logic [1:0] sel_code;
    logic pin_oe;
    logic pin_val;
    logic stored;
    logic mux_val;
  } status_t;
endpackage

//--- design/io_cell_axil_regs.sv
// Purpose: axi4-lite slave holding the cell configuration words
// Assumes: one write and one read in flight at most
// Notes: unmapped addresses answer slverr, reads of them return zero
`timescale 1ns/1ps
`default_nettype none
module io_cell_axil_regs (
  input wire logic ref_clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic [io_cell_pkg::ADDR_W-1:0] s_axi_awaddr_in, // write address
  input wire logic s_axi_awvalid_in, // write address valid
  output logic s_axi_awready_out, // write address ready
  input wire logic [31:0] s_axi_wdata_in, // write data
  input wire logic [3:0] s_axi_wstrb_in, // write byte strobes
  input wire logic s_axi_wvalid_in, // write data valid
  output logic s_axi_wready_out, // write data ready
  output logic [1:0] s_axi_bresp_out, // write response
  output logic s_axi_bvalid_out, // write response valid
  input wire logic s_axi_bready_in, // write response ready
  input wire logic [io_cell_pkg::ADDR_W-1:0] s_axi_araddr_in, // read address
  input wire logic s_axi_arvalid_in, // read address valid
  output logic s_axi_arready_out, // read address ready
  output logic [31:0] s_axi_rdata_out, // read data
  output logic [1:0] s_axi_rresp_out, // read response
  output logic s_axi_rvalid_out, // read data valid
  input wire logic s_axi_rready_in, // read data ready
  input wire io_cell_pkg::status_t status_in, // live cell state
  output io_cell_pkg::cfg_t cfg_out // configuration words
);
  logic aw_held;
  logic w_held;
  logic [io_cell_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign do_write = aw_held && w_held && !s_axi_bvalid_out;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_out.ctrl <= io_cell_pkg::CTRL_RESET;
      cfg_out.route <= io_cell_pkg::ROUTE_RESET;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= io_cell_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= io_cell_pkg::RESP_OKAY;
      if (aw_addr == io_cell_pkg::ADDR_CTRL) begin
        cfg_out.ctrl <= merge(cfg_out.ctrl, w_data, w_strb)
                        & ((32'h1 << io_cell_pkg::CTRL_USED) - 32'h1);
      end else if (aw_addr == io_cell_pkg::ADDR_ROUTE) begin
        cfg_out.route <= merge(cfg_out.route, w_data, w_strb)
                         & ((32'h1 << io_cell_pkg::ROUTE_USED) - 32'h1);
      end else begin
        s_axi_bresp_out <= io_cell_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= io_cell_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= io_cell_pkg::RESP_OKAY;
      unique case (s_axi_araddr_in)
        io_cell_pkg::ADDR_CTRL: s_axi_rdata_out <= cfg_out.ctrl;
        io_cell_pkg::ADDR_ROUTE: s_axi_rdata_out <= cfg_out.route;
        io_cell_pkg::ADDR_STATUS: s_axi_rdata_out <= {24'h000000, status_in};
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= io_cell_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
endmodule // io_cell_axil_regs
`default_nettype wire

//--- design/programmable_io_cell.sv
// Purpose: one programmable i/o cell: 4:1 select, storage element, pin drive
// Assumes: all pins and pool signals synchronous to ref_clk_in
// Notes: the storage clock is a sampled pin level, edges seen synchronously
`timescale 1ns/1ps
`default_nettype none
module programmable_io_cell (
  input wire logic ref_clk_in, // 10 mhz system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic power_stable_in, // high once supplies are settled
  input wire logic [io_cell_pkg::POOL_PINS-1:0] routing_pool_in, // pool of pin inputs
  input wire logic [3:0] dedicated_clock_in, // dedicated clocks, also global gates
  input wire logic [3:0] neighbour_select_in, // cells n-2, n-1, n+1, n+2
  input wire logic pin_in, // this cell's pin input level
  output logic pin_out, // this cell's pin output level
  output logic pin_oe_out, // pin output enable, high drives
  output logic neighbour_select_out, // this cell's select result to neighbours
  output logic pool_drive_out, // what this cell feeds into the pool
  input wire logic [io_cell_pkg::ADDR_W-1:0] s_axi_awaddr_in, // write address
  input wire logic s_axi_awvalid_in, // write address valid
  output logic s_axi_awready_out, // write address ready
  input wire logic [31:0] s_axi_wdata_in, // write data
  input wire logic [3:0] s_axi_wstrb_in, // write byte strobes
  input wire logic s_axi_wvalid_in, // write data valid
  output logic s_axi_wready_out, // write data ready
  output logic [1:0] s_axi_bresp_out, // write response
  output logic s_axi_bvalid_out, // write response valid
  input wire logic s_axi_bready_in, // write response ready
  input wire logic [io_cell_pkg::ADDR_W-1:0] s_axi_araddr_in, // read address
  input wire logic s_axi_arvalid_in, // read address valid
  output logic s_axi_arready_out, // read address ready
  output logic [31:0] s_axi_rdata_out, // read data
  output logic [1:0] s_axi_rresp_out, // read response
  output logic s_axi_rvalid_out, // read data valid
  input wire logic s_axi_rready_in // read data ready
);
  io_cell_pkg::cfg_t cfg;
  io_cell_pkg::status_t status;
  io_cell_pkg::store_mode_t store_mode;
  logic [3:0] data_src;
  logic [1:0] sel_code;
  logic sel_low;
  logic sel_high;
  logic mux_val;
  logic clk_raw;
  logic clk_active;
  logic clk_prev;
  logic clk_edge;
  logic gate_raw;
  logic gate_on;
  logic store_d;
  logic stored;
  logic store_q;
  logic path_val;
  logic final_val;
  logic oe_raw;
  logic oe_sel;
  logic input_path;

  // one pin of a quarter-sized set, picked by a two-bit index
  function automatic logic pick(input logic [io_cell_pkg::POOL_PINS-1:0] pool,
                                input int quarter, input logic [1:0] idx);
    return pool[quarter * io_cell_pkg::QUARTER + int'(idx)];
  endfunction

  // gray-ordered select: code 00,01,11,10 -> input 0,1,2,3
  function automatic logic gray_pick(input logic [3:0] src, input logic [1:0] code);
    logic res;
    res = 1'b0;
    unique case (code)
      2'b00: res = src[0];
      2'b01: res = src[1];
      2'b11: res = src[2];
      2'b10: res = src[3];
    endcase
    return res;
  endfunction

  io_cell_axil_regs u_regs (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .status_in(status),
    .cfg_out(cfg)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // data inputs: pool quarter k, or neighbour k when enabled
  generate
    for (genvar k = 0; k < 4; k++) begin : g_data
      logic direct;
      assign direct = pick(routing_pool_in, k,
                           cfg.route[io_cell_pkg::ROUTE_DATA_LSB + 2*k +: 2]);
      assign data_src[k] = cfg.route[io_cell_pkg::ROUTE_NBR_LSB + k]
                           ? neighbour_select_in[k] : direct;
    end
  endgenerate

  // select lines from set one or two, each with its own polarity
  always_comb begin
    logic lo_one;
    logic lo_two;
    logic hi_one;
    logic hi_two;
    lo_one = pick(routing_pool_in, io_cell_pkg::SET_SEL_ONE,
                  cfg.route[io_cell_pkg::ROUTE_SLO_LSB +: 2]);
    lo_two = pick(routing_pool_in, io_cell_pkg::SET_SEL_TWO,
                  cfg.route[io_cell_pkg::ROUTE_SLO_LSB +: 2]);
    hi_one = pick(routing_pool_in, io_cell_pkg::SET_SEL_ONE,
                  cfg.route[io_cell_pkg::ROUTE_SHI_LSB +: 2]);
    hi_two = pick(routing_pool_in, io_cell_pkg::SET_SEL_TWO,
                  cfg.route[io_cell_pkg::ROUTE_SHI_LSB +: 2]);
    sel_low = (cfg.ctrl[io_cell_pkg::CTRL_SLO_SET] ? lo_two : lo_one)
              ^ cfg.ctrl[io_cell_pkg::CTRL_SLO_INV];
    sel_high = (cfg.ctrl[io_cell_pkg::CTRL_SHI_SET] ? hi_two : hi_one)
               ^ cfg.ctrl[io_cell_pkg::CTRL_SHI_INV];
  end

  assign sel_code = {sel_high, sel_low};
  assign mux_val = gray_pick(data_src, sel_code);
  assign neighbour_select_out = mux_val;

  ////////////////////////////////////////////////////////////////////////////////
  // storage clock and gate, each from the shared clock pin set or the dedicated clock pins
  assign clk_raw = cfg.ctrl[io_cell_pkg::CTRL_CLK_DED]
                   ? dedicated_clock_in[cfg.route[io_cell_pkg::ROUTE_CLK_LSB +: 2]]
                   : pick(routing_pool_in, io_cell_pkg::SET_CLK,
                          cfg.route[io_cell_pkg::ROUTE_CLK_LSB +: 2]);
  assign clk_active = clk_raw ^ cfg.ctrl[io_cell_pkg::CTRL_CLK_INV];
  // dedicated clock pins serve as the global gate inputs too
  assign gate_raw = cfg.ctrl[io_cell_pkg::CTRL_GATE_GLB]
                    ? dedicated_clock_in[cfg.route[io_cell_pkg::ROUTE_GATE_LSB +: 2]]
                    : pick(routing_pool_in, io_cell_pkg::SET_CLK,
                           cfg.route[io_cell_pkg::ROUTE_GATE_LSB +: 2]);
  assign gate_on = gate_raw ^ cfg.ctrl[io_cell_pkg::CTRL_GATE_INV];

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_active;
    end
  end

  assign clk_edge = clk_active && !clk_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // storage element: latch, register or bypass
  assign input_path = cfg.ctrl[io_cell_pkg::CTRL_INPUT_PATH];
  assign store_mode = io_cell_pkg::store_mode_t'(cfg.ctrl[io_cell_pkg::CTRL_MODE_LSB +: 2]);
  assign store_d = input_path ? pin_in : mux_val;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stored <= 1'b0;
    end else begin
      unique case (store_mode)
        io_cell_pkg::STORE_LATCH: begin
          if (clk_active) begin
            stored <= store_d;
          end
        end
        io_cell_pkg::STORE_REG: begin
          if (clk_edge && gate_on) begin
            stored <= store_d;
          end
        end
        default: stored <= stored;
      endcase
    end
  end

  // latch is transparent while open; register shows its stored value, bypass passes store_d straight through
  always_comb begin
    unique case (store_mode)
      io_cell_pkg::STORE_LATCH: store_q = clk_active ? store_d : stored;
      io_cell_pkg::STORE_REG: store_q = stored;
      default: store_q = store_d;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output and pool drive
  assign path_val = input_path ? mux_val : store_q;
  assign pool_drive_out = input_path ? store_q : pin_in;
  assign final_val = path_val ^ cfg.ctrl[io_cell_pkg::CTRL_OUT_INV];
  assign pin_out = cfg.ctrl[io_cell_pkg::CTRL_CONST_EN]
                   ? cfg.ctrl[io_cell_pkg::CTRL_CONST_VAL] : final_val;

  assign oe_raw = pick(routing_pool_in, io_cell_pkg::SET_OE,
                       cfg.route[io_cell_pkg::ROUTE_OE_LSB +: 2]);
  assign oe_sel = oe_raw ^ cfg.ctrl[io_cell_pkg::CTRL_OE_INV];
  assign pin_oe_out = reset_n_in && power_stable_in && oe_sel;

  always_comb begin
    status.clk_active = clk_active;
    status.gate_on = gate_on;
    status.sel_code = sel_code;
    status.pin_oe = pin_oe_out;
    status.pin_val = pin_out;
    status.stored = stored;
    status.mux_val = mux_val;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_gray_code_one: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (sel_code == 2'b01) |-> (mux_val == data_src[1]))
    else $error("select 01 did not pick input 1");
  a_gray_code_three: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (sel_code == 2'b10) |-> (mux_val == data_src[3]))
    else $error("select 10 did not pick input 3");
  a_gray_code_two: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (sel_code == 2'b11) |-> (mux_val == data_src[2]))
    else $error("select 11 did not pick input 2");
  a_neighbour_replaces: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      cfg.route[io_cell_pkg::ROUTE_NBR_LSB] |-> (data_src[0] == neighbour_select_in[0]))
    else $error("neighbour input did not replace pool source");
  a_gate_holds_reg: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (store_mode == io_cell_pkg::STORE_REG && !gate_on) ##1
      (store_mode == io_cell_pkg::STORE_REG) |-> (stored == $past(stored)))
    else $error("register changed with gate off");
  a_reg_captures: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (store_mode == io_cell_pkg::STORE_REG && clk_edge && gate_on) |=>
      (stored == $past(store_d)))
    else $error("register missed its clock edge");
  a_reg_no_edge: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (store_mode == io_cell_pkg::STORE_REG && !clk_edge) ##1
      (store_mode == io_cell_pkg::STORE_REG) |-> $stable(stored))
    else $error("register changed without a clock edge");
  a_latch_passes: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (store_mode == io_cell_pkg::STORE_LATCH && clk_active) |=>
      (stored == $past(store_d)))
    else $error("open latch not transparent");
  a_latch_holds: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (store_mode == io_cell_pkg::STORE_LATCH && !clk_active) ##1
      (store_mode == io_cell_pkg::STORE_LATCH && !clk_active) |-> $stable(store_q))
    else $error("closed latch changed");
  a_bypass_output: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (store_mode == io_cell_pkg::STORE_BYPASS && !input_path &&
       !cfg.ctrl[io_cell_pkg::CTRL_CONST_EN]) |->
      (pin_out == (mux_val ^ cfg.ctrl[io_cell_pkg::CTRL_OUT_INV])))
    else $error("combinational output wrong");
  a_input_to_pool: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (input_path && store_mode == io_cell_pkg::STORE_REG) |->
      (pool_drive_out == stored))
    else $error("input placement not feeding pool");
  a_constant_level: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      cfg.ctrl[io_cell_pkg::CTRL_CONST_EN] |->
      (pin_out == cfg.ctrl[io_cell_pkg::CTRL_CONST_VAL]))
    else $error("constant output level wrong");
  a_power_off_oe: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      !power_stable_in |-> !pin_oe_out)
    else $error("driver enabled while power unstable");
  a_oe_follows_pin: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      power_stable_in |-> (pin_oe_out == (oe_raw ^ cfg.ctrl[io_cell_pkg::CTRL_OE_INV])))
    else $error("output enable not following its pin");
endmodule // programmable_io_cell
`default_nettype wire

//--- verif/pin_board_model.sv
// Purpose: board side of the cell: pool pins and the cell's own pin
// Assumes: bench places pool levels at rising clock edges
// Notes: an undriven pin shows the board's own level
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  input wire logic [15:0] pool_set_in, // levels placed on the pool pins
  input wire logic board_level_in, // level the board puts on the pin
  input wire logic pin_out_in, // cell output level
  input wire logic pin_oe_in, // cell drive enable
  output logic [15:0] routing_pool_out, // pool pins as the cell sees them
  output logic pin_level_out // resolved pin level
);
  assign routing_pool_out = pool_set_in;
  assign pin_level_out = pin_oe_in ? pin_out_in : board_level_in;
endmodule // pin_board_model
`default_nettype wire

//--- verif/testbench.sv
// Purpose: self-checking bench for one programmable i/o cell
// Assumes: bus master waits for each answer, no fixed latency
// Notes: pool pins 9 and 10 act as select_low and select_high, except pins 12 and 8 in input_place
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, pwr = 1, board = 1;
  logic [15:0] pool = 0;
  logic [3:0] ded = 0, nbr = 0, strb = 4'hf;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic awvalid = 0, wvalid = 0, arvalid = 0, bready = 0, rready = 0;
  logic [1:0] rs;
  wire logic awready, wready, bvalid, arready, rvalid, pin_o, oe, nso, pdo, pin_l;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] pool_w;
  int fail_count = 0, check_count = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  pin_board_model board_side (.pool_set_in(pool), .board_level_in(board), .pin_out_in(pin_o),
    .pin_oe_in(oe), .routing_pool_out(pool_w), .pin_level_out(pin_l));
  programmable_io_cell dut (.ref_clk_in(clk), .reset_n_in(rst_n), .power_stable_in(pwr),
    .routing_pool_in(pool_w), .dedicated_clock_in(ded), .neighbour_select_in(nbr),
    .pin_in(pin_l), .pin_out(pin_o), .pin_oe_out(oe), .neighbour_select_out(nso),
    .pool_drive_out(pdo), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one write (w=1) or one read, each channel released at its own ready
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    bready <= w;
    rready <= !w;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (bvalid || rvalid) break;
    end
    rd = rdata;
    rs = w ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
    if (n == 40) begin
      fail_count++;
      final_report();
    end
    #10;
  endtask
  task automatic cfg(input logic [31:0] c, input logic [31:0] r);
    bus(1, io_cell_pkg::ADDR_CTRL, c);
    bus(1, io_cell_pkg::ADDR_ROUTE, r);
  endtask
  // pool change, then three edges so registered paths settle
  task automatic drive(input logic [15:0] v);
    @(posedge clk);
    pool <= v;
    repeat (3) @(posedge clk);
    #10;
  endtask
  // dedicated pins and board level, then a pool change
  task automatic pins(input logic [3:0] d, input logic b, input logic [15:0] v);
    @(posedge clk);
    ded <= d;
    board <= b;
    drive(v);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic regs_check;
    bus(0, io_cell_pkg::ADDR_CTRL, 0);
    chk("ctrl reset", rd, io_cell_pkg::CTRL_RESET);
    bus(1, io_cell_pkg::ADDR_CTRL, 32'hffff_ffff);
    bus(0, io_cell_pkg::ADDR_CTRL, 0);
    chk("ctrl bits", rd, 32'h0000_7fff);
    bus(1, io_cell_pkg::ADDR_STATUS, 0);
    chk("status write resp", rs, io_cell_pkg::RESP_SLVERR);
    bus(0, 8'h0c, 0);
    chk("unmapped data", rd, 0);
    chk("unmapped resp", rs, io_cell_pkg::RESP_SLVERR);
    bus(1, io_cell_pkg::ADDR_ROUTE, 32'hffff_ffff);
    @(posedge clk);
    strb <= 4'h2;
    bus(1, io_cell_pkg::ADDR_ROUTE, 0);
    bus(0, io_cell_pkg::ADDR_ROUTE, 0);
    chk("route bits and strobe", rd, 32'h003f_00ff);
    @(posedge clk);
    strb <= 4'hf;
  endtask
  // input placement, dedicated clock 0, global gate 1, select_low from set two
  task automatic input_place;
    cfg(32'h0000_3806, 32'h0001_0000);
    pins(4'h2, 1'b1, 16'h1010);
    chk("set two select", nso, 1);
    chk("select to pin", pin_o, 1);
    chk("pool before edge", pdo, 0);
    pins(4'h3, 1'b1, 16'h1010);
    chk("pin captured to pool", pdo, 1);
    pins(4'h0, 1'b0, 16'h1010);
    pins(4'h1, 1'b0, 16'h1010);
    chk("global gate holds", pdo, 1);
    bus(0, io_cell_pkg::ADDR_STATUS, 0);
    chk("status word", rd, 32'h0000_0097);
  endtask
  task automatic gray_select;
    logic [1:0] pick [4];
    int c;
    pick = '{2'h0, 2'h1, 2'h3, 2'h2};
    cfg(0, 32'h0024_0000);
    for (c = 0; c < 4; c++) begin
      drive((16'(c) << 9) | (16'h1 << (4 * pick[c])));
      chk("select one", nso, 1);
      chk("pin follows", pin_o, 1);
      drive((16'(c) << 9) | (16'h1111 & ~(16'h1 << (4 * pick[c]))));
      chk("select zero", nso, 0);
    end
    cfg(32'h0000_0200, 32'h0024_0000);
    drive(16'h0010);
    chk("select inverted", nso, 1);
    cfg(0, 32'h0024_0100);
    @(posedge clk);
    nbr <= 4'h1;
    drive(16'h0000);
    chk("neighbour in", nso, 1);
  endtask
  task automatic storage;
    cfg(32'h2, 32'h0026_4000);
    drive(16'h0021);
    drive(16'h0001);
    chk("gate off holds", pin_o, 0);
    drive(16'h0041);
    drive(16'h0061);
    chk("edge capture", pin_o, 1);
    drive(16'h0060);
    chk("no level pass", pin_o, 1);
    cfg(32'h1, 32'h0026_4000);
    drive(16'h0021);
    chk("latch open", pin_o, 1);
    drive(16'h0020);
    drive(16'h0000);
    drive(16'h0001);
    chk("latch hold", pin_o, 0);
  endtask
  task automatic out_drive;
    cfg(32'h8, 32'h0024_3000);
    drive(16'h0009);
    chk("inverted out", pin_o, 0);
    chk("oe on", oe, 1);
    chk("pin driven", pin_l, 0);
    chk("pin to pool", pdo, 0);
    cfg(32'h30, 32'h0024_3000);
    chk("const high", pin_o, 1);
    cfg(32'h50, 32'h0024_3000);
    chk("const low", pin_o, 0);
    chk("oe inverted", oe, 0);
    @(posedge clk);
    pwr <= 1'b0;
    drive(16'h0000);
    chk("oe power off", oe, 0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    regs_check();
    gray_select();
    storage();
    out_drive();
    input_place();
    final_report();
  end
endmodule // testbench
`default_nettype wire
